// ---- verilog/upswc_pkg.sv ----
`default_nettype none
package upswc_pkg;
  // =====================================
  // Register map
  localparam logic [7:0] ADDR_CTRL = 8'h00;
  localparam logic [7:0] ADDR_TIMEOUT = 8'h04;
  localparam logic [7:0] ADDR_STATUS = 8'h08;
  localparam logic [7:0] ADDR_MUXMAP = 8'h0c;
  localparam int CTRL_SET_LSB = 0;
  localparam int CTRL_FLOW_BIT = 3;
  localparam int CTRL_VAR_LSB = 4;
  localparam int STAT_MODE_LSB = 0;
  localparam int STAT_PORT_BIT = 2;
  localparam int STAT_ACC_BIT = 3;
  localparam int STAT_WIN_BIT = 4;
  localparam int STAT_REF_BIT = 5;
  localparam int STAT_RTS_BIT = 6;
  localparam int STAT_DTR_BIT = 7;
  localparam int MAP_CMD_LSB = 0;
  localparam int MAP_GNSS_LSB = 3;
  localparam int MAP_GPRI_BIT = 6;
  localparam int MAP_CAUX_BIT = 7;
  localparam int MAP_TAUX_BIT = 8;
  // =====================================
  // Power save settings and reset values
  localparam logic [2:0] PS_OFF = 3'h0;
  localparam logic [2:0] PS_TIMED = 3'h1;
  localparam logic [2:0] PS_RTS = 3'h2;
  localparam logic [2:0] PS_DTR = 3'h3;
  localparam logic [2:0] PS_TIMED_ALT = 3'h4;
  localparam logic [2:0] SETTING_RST = PS_OFF;
  localparam logic FLOW_RST = 1'b0;
  localparam logic [2:0] VARIANT_RST = 3'h0;
  localparam logic [2:0] VARIANT_SINGLE_MAX = 3'h1;
  localparam logic [2:0] VARIANT_MAX = 3'h4;
  localparam logic [15:0] TIMEOUT_RST = 16'h07d0;
  // =====================================
  // Multiplexer channel numbers
  localparam logic [2:0] CH_CMD_LAST_2 = 3'h2;
  localparam logic [2:0] CH_CMD_LAST_3 = 3'h3;
  localparam logic [2:0] CH_GNSS_3 = 3'h3;
  localparam logic [2:0] CH_GNSS_4 = 3'h4;
  localparam logic [2:0] CH_NONE = 3'h7;
  // =====================================
  // Timing
  localparam int WAKE_TIME_MS = 15;
  localparam int CLK_FREQ_KHZ = 250000;
  localparam int WAKE_CYCLES = WAKE_TIME_MS * CLK_FREQ_KHZ;
  localparam int FRAME_CYCLES = 1000;
  typedef enum logic [1:0] {ST_ACTIVE, ST_IDLE, ST_WAKING, ST_DEEP} upswc_state_t;
endpackage
`default_nettype wire

// ---- verilog/upswc_mux_map.sv ----
`timescale 1ns/1ps
`default_nettype none
module upswc_mux_map (
  input wire logic [2:0] variant_i,
  output logic [2:0] cmd_last_o,
  output logic [2:0] gnss_ch_o,
  output logic gnss_primary_o,
  output logic cmd_aux_o,
  output logic trace_aux_o
);
  // =====================================
  // Channel map per port variant
  always_comb begin
    cmd_last_o = upswc_pkg::CH_CMD_LAST_3;
    gnss_ch_o = upswc_pkg::CH_GNSS_4;
    gnss_primary_o = 1'b1;
    cmd_aux_o = 1'b0;
    trace_aux_o = 1'b0;
    case (variant_i)
      3'h2: begin
        cmd_last_o = upswc_pkg::CH_CMD_LAST_2;
        gnss_ch_o = upswc_pkg::CH_GNSS_3;
        cmd_aux_o = 1'b1;
      end
      3'h3: begin
        trace_aux_o = 1'b1;
      end
      3'h4: begin
        gnss_ch_o = upswc_pkg::CH_NONE;
        gnss_primary_o = 1'b0;
      end
      default: begin
        cmd_last_o = upswc_pkg::CH_CMD_LAST_3;
      end
    endcase
  end
endmodule
`default_nettype wire

// ---- verilog/upswc_top.sv ----
// Functional notes
// - Setting 2 accepted only with hardware flow control off; otherwise refused.
// - Setting 2: port disabled at once and kept off while RTS is OFF.
// - Setting 2, RTS OFF: port still on for unsolicited message or data session.
// - Setting 2: RTS OFF-to-ON re-enables port; idle device active after wake time.
// - Setting 2: RTS ON forbids idle and deep sleep, keeps port enabled.
// - Setting 3 accepted only with serial port variant 0 or 1.
// - Setting 3: DTR OFF disables port except while unsolicited message pending.
// - Setting 3: DTR OFF-to-ON re-enables port; idle device active after wake time.
// - Setting 3: DTR ON forbids idle and deep sleep, keeps port enabled.
// - Setting 3: DTR still feeds its separately configured behaviour.
// - Deep sleep always makes the port non-functional.
// - Idle with data wake armed: RXD OFF-to-ON wakes port, active after wake time.
// - Wake character discarded; reception valid only after wake time.
// - Data wake armed only in settings 1 or 4 with flow control off.
// - Setting 2 RTS OFF or setting 3 DTR OFF: no data wake, input dropped.
// - Data wake has no disable control.
// - After data wake, port off once inactivity timeout since last character expires.
// - Variant 0 or 1: channel 0 control, 1 to 3 commands, 4 GNSS.
// - Variant 2: commands on aux; 0 control, 1 to 2 commands, 3 GNSS.
// - Variant 3: trace on aux; 0 control, 1 to 3 commands, 4 GNSS.
// - Variant 4: GNSS on aux; 0 control, 1 to 3 commands only.
// - With flow control on, CTS reflects port enabled state.
// - CTS low while port enabled; high while disabled only with flow control on.
// - Setting 0 default: never idle, port enabled, CTS held ON.
`timescale 1ns/1ps
`default_nettype none
module upswc_top #(
  parameter int unsigned WAKE_CYCLES = upswc_pkg::WAKE_CYCLES,
  parameter int unsigned FRAME_CYCLES = upswc_pkg::FRAME_CYCLES
) (
  input wire logic ref_clk_i,
  input wire logic reset_n_i,
  input wire logic [7:0] addr_i,
  input wire logic [31:0] wdata_i,
  input wire logic wr_i,
  input wire logic rd_i,
  input wire logic rts_n_i,
  input wire logic dtr_n_i,
  input wire logic rxd_i,
  input wire logic rx_char_i,
  input wire logic unsolicited_result_message_i,
  input wire logic packet_data_session_i,
  input wire logic idle_ok_i,
  input wire logic deep_ok_i,
  output logic [31:0] rdata_o,
  output logic port_enable_o,
  output logic rx_accept_o,
  output logic cts_n_o,
  output logic [1:0] mode_o,
  output logic dtr_on_o
);
  // =====================================
  // Declarations
  upswc_pkg::upswc_state_t state_reg, state_next;
  logic [2:0] setting_reg;
  logic flow_reg;
  logic [2:0] variant_reg;
  logic [15:0] timeout_reg;
  logic refused_reg;
  logic [2:0] pin_w;
  logic [2:0] pin_prev_reg;
  logic [31:0] wake_cnt_reg;
  logic [31:0] tick_cnt_reg;
  logic [15:0] frame_cnt_reg;
  logic port_en_reg, port_en_next;
  logic rx_acc_reg, rx_acc_next;
  logic cts_n_reg;
  logic dtr_on_reg;
  logic [31:0] rdata_reg;
  logic [2:0] map_cmd_last, map_gnss_ch;
  logic map_gnss_pri, map_cmd_aux, map_trace_aux;
  logic [31:0] status_w, muxmap_w;
  logic [2:0] new_set, new_var;
  logic new_flow, ctrl_wr, ctrl_bad;
  logic set0, set2, set3, set14;
  logic rts_on, dtr_on, rts_rise, dtr_rise, rxd_fall;
  logic data_armed, win_active, blocked, hold, port_req, wake_trig, win_load;

  // =====================================
  // Pin synchronisers, index 0 RTS, 1 DTR, 2 RXD
  for (genvar gi = 0; gi < 3; gi++) begin : g_sync
    logic s1_reg, s2_reg, s3_reg, pin_reg;
    always_ff @(posedge ref_clk_i or negedge reset_n_i) begin
      if (!reset_n_i) begin
        s1_reg <= 1'b1;
        s2_reg <= 1'b1;
        s3_reg <= 1'b1;
        pin_reg <= 1'b1;
      end else begin
        s1_reg <= (gi == 0) ? rts_n_i : ((gi == 1) ? dtr_n_i : rxd_i);
        s2_reg <= s1_reg;
        s3_reg <= s2_reg;
        if (s2_reg == s3_reg) begin
          pin_reg <= s3_reg;
        end
      end
    end
    assign pin_w[gi] = pin_reg;
  end

  always_ff @(posedge ref_clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      pin_prev_reg <= 3'h7;
    end else begin
      pin_prev_reg <= pin_w;
    end
  end

  // Lines are active low: low level means ON
  assign rts_on = ~pin_w[0];
  assign dtr_on = ~pin_w[1];
  assign rts_rise = pin_prev_reg[0] & ~pin_w[0];
  assign dtr_rise = pin_prev_reg[1] & ~pin_w[1];
  assign rxd_fall = pin_prev_reg[2] & ~pin_w[2];

  // =====================================
  // Mode decode
  assign set0 = (setting_reg == upswc_pkg::PS_OFF);
  assign set2 = (setting_reg == upswc_pkg::PS_RTS);
  assign set3 = (setting_reg == upswc_pkg::PS_DTR);
  assign set14 = (setting_reg == upswc_pkg::PS_TIMED) | (setting_reg == upswc_pkg::PS_TIMED_ALT);
  assign data_armed = set14 & ~flow_reg;
  assign blocked = (set2 & ~rts_on) | (set3 & ~dtr_on);
  assign hold = set0 | (set2 & rts_on) | (set3 & dtr_on);
  assign win_active = (frame_cnt_reg != 16'h0);

  always_comb begin
    port_req = hold | unsolicited_result_message_i;
    if ((set2 | set14) && packet_data_session_i) begin
      port_req = 1'b1;
    end
    if (set14 && win_active) begin
      port_req = 1'b1;
    end
  end

  assign wake_trig = hold | unsolicited_result_message_i | (set2 & rts_rise) | (set3 & dtr_rise)
    | (data_armed & rxd_fall) | ((set2 | set14) & packet_data_session_i);

  // =====================================
  // Power state machine
  always_comb begin
    state_next = state_reg;
    case (state_reg)
      upswc_pkg::ST_ACTIVE: begin
        if (data_armed && rxd_fall && !port_en_reg) begin
          state_next = upswc_pkg::ST_WAKING;
        end else if (!hold && !port_req && idle_ok_i) begin
          state_next = upswc_pkg::ST_IDLE;
        end
      end
      upswc_pkg::ST_IDLE: begin
        if (wake_trig) begin
          state_next = upswc_pkg::ST_WAKING;
        end else if (deep_ok_i) begin
          state_next = upswc_pkg::ST_DEEP;
        end
      end
      upswc_pkg::ST_WAKING: begin
        if (wake_cnt_reg >= WAKE_CYCLES - 1) begin
          state_next = upswc_pkg::ST_ACTIVE;
        end
      end
      upswc_pkg::ST_DEEP: begin
        if (hold || !deep_ok_i) begin
          state_next = upswc_pkg::ST_WAKING;
        end
      end
      default: begin
        state_next = upswc_pkg::ST_ACTIVE;
      end
    endcase
  end

  always_ff @(posedge ref_clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      state_reg <= upswc_pkg::ST_ACTIVE;
    end else begin
      state_reg <= state_next;
    end
  end

  always_ff @(posedge ref_clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      wake_cnt_reg <= 32'h0;
    end else if (state_reg == upswc_pkg::ST_WAKING && state_next == upswc_pkg::ST_WAKING) begin
      wake_cnt_reg <= wake_cnt_reg + 32'h1;
    end else begin
      wake_cnt_reg <= 32'h0;
    end
  end

  // =====================================
  // Inactivity window after data wake
  // reload on wake char or any character
  assign win_load = data_armed & ((rxd_fall & ~port_en_reg) | (rx_char_i & port_en_reg));

  always_ff @(posedge ref_clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      frame_cnt_reg <= 16'h0;
      tick_cnt_reg <= 32'h0;
    end else if (win_load) begin
      frame_cnt_reg <= timeout_reg;
      tick_cnt_reg <= 32'h0;
    end else if (!data_armed) begin
      frame_cnt_reg <= 16'h0;
      tick_cnt_reg <= 32'h0;
    end else if (win_active) begin
      if (tick_cnt_reg >= FRAME_CYCLES - 1) begin
        tick_cnt_reg <= 32'h0;
        frame_cnt_reg <= frame_cnt_reg - 16'h1;
      end else begin
        tick_cnt_reg <= tick_cnt_reg + 32'h1;
      end
    end
  end

  // =====================================
  // Port enable, receive gate, CTS
  // deep sleep kills the port
  assign port_en_next = port_req & (state_next != upswc_pkg::ST_DEEP);
  assign rx_acc_next = port_en_next & (state_next == upswc_pkg::ST_ACTIVE) & ~blocked;

  always_ff @(posedge ref_clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      port_en_reg <= 1'b1;
      rx_acc_reg <= 1'b1;
      cts_n_reg <= 1'b0;
      dtr_on_reg <= 1'b0;
    end else begin
      port_en_reg <= port_en_next;
      rx_acc_reg <= rx_acc_next;
      // CTS ON (low) when port enabled
      cts_n_reg <= flow_reg & ~port_en_next;
      // DTR passed on to its own handling
      dtr_on_reg <= dtr_on;
    end
  end

  // =====================================
  // Register interface
  assign new_set = wdata_i[upswc_pkg::CTRL_SET_LSB +: 3];
  assign new_flow = wdata_i[upswc_pkg::CTRL_FLOW_BIT];
  assign new_var = wdata_i[upswc_pkg::CTRL_VAR_LSB +: 3];
  assign ctrl_wr = wr_i & (addr_i == upswc_pkg::ADDR_CTRL);

  assign ctrl_bad = (new_set > upswc_pkg::PS_TIMED_ALT) | (new_var > upswc_pkg::VARIANT_MAX)
    | ((new_set == upswc_pkg::PS_RTS) & new_flow)
    | ((new_set == upswc_pkg::PS_DTR) & (new_var > upswc_pkg::VARIANT_SINGLE_MAX));

  always_ff @(posedge ref_clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      setting_reg <= upswc_pkg::SETTING_RST;
      flow_reg <= upswc_pkg::FLOW_RST;
      variant_reg <= upswc_pkg::VARIANT_RST;
    end else if (ctrl_wr && !ctrl_bad) begin
      setting_reg <= new_set;
      flow_reg <= new_flow;
      variant_reg <= new_var;
    end
  end

  always_ff @(posedge ref_clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      timeout_reg <= upswc_pkg::TIMEOUT_RST;
    end else if (wr_i && addr_i == upswc_pkg::ADDR_TIMEOUT) begin
      timeout_reg <= wdata_i[15:0];
    end
  end

  // Refusal flag, set wins over write-one-to-clear
  always_ff @(posedge ref_clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      refused_reg <= 1'b0;
    end else if (ctrl_wr && ctrl_bad) begin
      refused_reg <= 1'b1;
    end else if (wr_i && addr_i == upswc_pkg::ADDR_STATUS && wdata_i[upswc_pkg::STAT_REF_BIT]) begin
      refused_reg <= 1'b0;
    end
  end

  upswc_mux_map u_mux_map (
    .variant_i(variant_reg),
    .cmd_last_o(map_cmd_last),
    .gnss_ch_o(map_gnss_ch),
    .gnss_primary_o(map_gnss_pri),
    .cmd_aux_o(map_cmd_aux),
    .trace_aux_o(map_trace_aux)
  );

  always_comb begin
    status_w = 32'h0;
    status_w[upswc_pkg::STAT_MODE_LSB +: 2] = state_reg;
    status_w[upswc_pkg::STAT_PORT_BIT] = port_en_reg;
    status_w[upswc_pkg::STAT_ACC_BIT] = rx_acc_reg;
    status_w[upswc_pkg::STAT_WIN_BIT] = win_active;
    status_w[upswc_pkg::STAT_REF_BIT] = refused_reg;
    status_w[upswc_pkg::STAT_RTS_BIT] = rts_on;
    status_w[upswc_pkg::STAT_DTR_BIT] = dtr_on;
    muxmap_w = 32'h0;
    muxmap_w[upswc_pkg::MAP_CMD_LSB +: 3] = map_cmd_last;
    muxmap_w[upswc_pkg::MAP_GNSS_LSB +: 3] = map_gnss_ch;
    muxmap_w[upswc_pkg::MAP_GPRI_BIT] = map_gnss_pri;
    muxmap_w[upswc_pkg::MAP_CAUX_BIT] = map_cmd_aux;
    muxmap_w[upswc_pkg::MAP_TAUX_BIT] = map_trace_aux;
  end

  // Read data valid only in the cycle after the strobe
  always_ff @(posedge ref_clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      rdata_reg <= 32'h0;
    end else if (rd_i) begin
      case (addr_i)
        upswc_pkg::ADDR_CTRL: rdata_reg <= {25'h0, variant_reg, flow_reg, setting_reg};
        upswc_pkg::ADDR_TIMEOUT: rdata_reg <= {16'h0, timeout_reg};
        upswc_pkg::ADDR_STATUS: rdata_reg <= status_w;
        upswc_pkg::ADDR_MUXMAP: rdata_reg <= muxmap_w;
        default: rdata_reg <= 32'h0;
      endcase
    end else begin
      rdata_reg <= 32'h0;
    end
  end

  assign rdata_o = rdata_reg;
  assign port_enable_o = port_en_reg;
  assign rx_accept_o = rx_acc_reg;
  assign cts_n_o = cts_n_reg;
  assign mode_o = state_reg;
  assign dtr_on_o = dtr_on_reg;

  // =====================================
  // Assertions
  default clocking cb @(posedge ref_clk_i);
  endclocking
  default disable iff (!reset_n_i);

  a_set2_flow_refused: assert property (ctrl_wr && new_set == upswc_pkg::PS_RTS && new_flow
    |=> setting_reg == $past(setting_reg) && refused_reg) else $error("setting 2 taken with flow control on");
  a_rts_off_disable: assert property (set2 && !rts_on && !unsolicited_result_message_i && !packet_data_session_i
    |=> !port_enable_o) else $error("port enabled with RTS off");
  a_rts_off_unsol: assert property (set2 && unsolicited_result_message_i && state_next != upswc_pkg::ST_DEEP
    |=> port_enable_o) else $error("unsolicited message did not enable port");
  a_rts_rise_wake: assert property (set2 && rts_rise && state_reg == upswc_pkg::ST_IDLE
    |=> state_reg == upswc_pkg::ST_WAKING && port_enable_o) else $error("RTS edge did not wake");
  a_rts_on_hold: assert property (set2 && rts_on && state_reg == upswc_pkg::ST_ACTIVE
    |=> state_reg == upswc_pkg::ST_ACTIVE) else $error("idle entered with RTS on");
  a_set3_variant: assert property (ctrl_wr && new_set == upswc_pkg::PS_DTR && new_var > 3'h1
    |=> $stable(setting_reg)) else $error("setting 3 taken with dual port variant");
  a_dtr_off_disable: assert property (set3 && !dtr_on && !unsolicited_result_message_i
    |=> !port_enable_o) else $error("port enabled with DTR off");
  a_dtr_on_hold: assert property (set3 && dtr_on && state_reg == upswc_pkg::ST_IDLE
    |=> state_reg == upswc_pkg::ST_WAKING) else $error("DTR on did not leave idle");
  a_deep_port_off: assert property (state_reg == upswc_pkg::ST_DEEP
    |-> !port_enable_o && !rx_accept_o) else $error("port alive in deep sleep");
  a_wake_time: assert property (state_reg == upswc_pkg::ST_WAKING && wake_cnt_reg == WAKE_CYCLES - 1
    |=> state_reg == upswc_pkg::ST_ACTIVE ##1 wake_cnt_reg == 32'h0) else $error("wake time wrong");
  a_wake_no_accept: assert property (state_reg != upswc_pkg::ST_ACTIVE
    |-> !rx_accept_o) else $error("input accepted before wake done");
  a_blocked_drop: assert property (blocked |=> !rx_accept_o) else $error("blocked input accepted");
  a_cts_follows: assert property (flow_reg && $stable(flow_reg)
    |-> cts_n_o == !port_enable_o) else $error("CTS does not follow port");
  a_setting0_on: assert property (set0 && $past(set0)
    |-> port_enable_o && !cts_n_o) else $error("setting 0 port not enabled");

  c_data_wake: cover property (data_armed && rxd_fall && state_reg == upswc_pkg::ST_IDLE
    ##1 state_reg == upswc_pkg::ST_WAKING);
  c_refused: cover property (ctrl_wr && ctrl_bad);
  c_deep: cover property (state_reg == upswc_pkg::ST_IDLE ##1 state_reg == upswc_pkg::ST_DEEP);
  c_window_end: cover property (win_active ##1 !win_active);
endmodule
`default_nettype wire

// ---- bench/upswc_dte_model.sv ----
`timescale 1ns/1ps
`default_nettype none
module upswc_dte_model (
  input wire logic ref_clk_i,
  input wire logic reset_n_i,
  input wire logic rts_on_i,
  input wire logic dtr_on_i,
  input wire logic send_i,
  output logic rts_n_o,
  output logic dtr_n_o,
  output logic rxd_o,
  output logic rx_char_o
);
  logic [2:0] bit_cnt_reg;

  // =====================================
  // Control lines, low level means ON
  always_ff @(posedge ref_clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      rts_n_o <= 1'b1;
      dtr_n_o <= 1'b1;
    end else begin
      rts_n_o <= ~rts_on_i;
      dtr_n_o <= ~dtr_on_i;
    end
  end

  // =====================================
  // Character: start bit held 4 cycles, then idle high
  always_ff @(posedge ref_clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      bit_cnt_reg <= 3'h0;
      rx_char_o <= 1'b0;
    end else begin
      rx_char_o <= (bit_cnt_reg == 3'h1);
      if (send_i && bit_cnt_reg == 3'h0) begin
        bit_cnt_reg <= 3'h4;
      end else if (bit_cnt_reg != 3'h0) begin
        bit_cnt_reg <= bit_cnt_reg - 3'h1;
      end
    end
  end

  assign rxd_o = (bit_cnt_reg == 3'h0);
endmodule
`default_nettype wire

// ---- bench/upswc_top_bench.sv ----
`timescale 1ns/1ps
`default_nettype none
`define CHK(a, b) begin cmp_count++; if ((a) !== (b)) begin fail_count++; \
  $display("[ERR] %0t got %h want %h", $time, a, b); end end
module upswc_top_bench;
  localparam int WAKE = 20;
  logic clk = 1'b0;
  logic reset_n = 1'b0;
  logic [7:0] addr = 8'h00;
  logic [31:0] wdata = 32'h0;
  logic wr = 1'b0;
  logic rd = 1'b0;
  logic unsol = 1'b0;
  logic session = 1'b0;
  logic idle_ok = 1'b0;
  logic deep_ok = 1'b0;
  logic rts_on = 1'b0;
  logic dtr_on = 1'b0;
  logic send = 1'b0;
  logic rts_n, dtr_n, rxd, rx_char;
  logic [31:0] rdata;
  logic port_en, rx_acc, cts_n, dtr_seen;
  logic [1:0] mode;
  logic [31:0] rv;
  logic [6:0] w, exp_ctrl;
  logic [6:0] corner [4] = '{7'h0a, 7'h23, 7'h13, 7'h02};
  int fail_count = 0;
  int cmp_count = 0;
  int cyc = 0;

  initial begin
    forever #2 clk = ~clk;
  end

  upswc_top #(.WAKE_CYCLES(WAKE), .FRAME_CYCLES(4)) DUT (.ref_clk_i(clk), .reset_n_i(reset_n),
    .addr_i(addr), .wdata_i(wdata), .wr_i(wr), .rd_i(rd), .rts_n_i(rts_n), .dtr_n_i(dtr_n),
    .rxd_i(rxd), .rx_char_i(rx_char), .unsolicited_result_message_i(unsol), .packet_data_session_i(session),
    .idle_ok_i(idle_ok), .deep_ok_i(deep_ok), .rdata_o(rdata), .port_enable_o(port_en), .rx_accept_o(rx_acc),
    .cts_n_o(cts_n), .mode_o(mode), .dtr_on_o(dtr_seen));

  upswc_dte_model host (.ref_clk_i(clk), .reset_n_i(reset_n), .rts_on_i(rts_on), .dtr_on_i(dtr_on),
    .send_i(send), .rts_n_o(rts_n), .dtr_n_o(dtr_n), .rxd_o(rxd), .rx_char_o(rx_char));

  task automatic report_and_stop;
    $display("comparisons %0d mismatches %0d", cmp_count, fail_count);
    if (fail_count == 0 && cmp_count > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask

  always @(posedge clk) begin
    cyc++;
    if (cyc == 20000) begin
      fail_count++;
      report_and_stop;
    end
  end

  task automatic wr_reg(input logic [7:0] a, input logic [31:0] d);
    @(posedge clk);
    addr <= a;
    wdata <= d;
    wr <= 1'b1;
    @(posedge clk);
    wr <= 1'b0;
  endtask

  task automatic rd_reg(input logic [7:0] a);
    @(posedge clk);
    addr <= a;
    rd <= 1'b1;
    @(posedge clk);
    rd <= 1'b0;
    #1 rv = rdata;
  endtask

  task automatic wait_cyc(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask

  task automatic wait_st(input logic [1:0] m, input int lim);
    int i;
    i = 0;
    #1;
    while (mode !== m && i < lim) begin
      @(posedge clk);
      #1 i++;
    end
    `CHK(mode, m)
  endtask

  task automatic send_char;
    @(posedge clk);
    send <= 1'b1;
    @(posedge clk);
    send <= 1'b0;
  endtask

  task automatic set_pin(input logic d, input logic v);
    @(posedge clk);
    if (d) begin
      dtr_on <= v;
    end else begin
      rts_on <= v;
    end
  endtask

  function automatic logic ctrl_ok(input logic [6:0] c);
    return c[2:0] <= 3'h4 && c[6:4] <= 3'h4 && !(c[2:0] == 3'h2 && c[3]) && !(c[2:0] == 3'h3 && c[6:4] > 3'h1);
  endfunction

  function automatic logic [8:0] map_exp(input logic [2:0] v);
    logic [2:0] g;
    g = (v == 3'h2) ? 3'h3 : (v == 3'h4) ? 3'h7 : 3'h4;
    return {v == 3'h3, v == 3'h2, v != 3'h4, g, (v == 3'h2) ? 3'h2 : 3'h3};
  endfunction

  // =====================================
  // Line controlled power save, setting 2 on RTS or 3 on DTR
  task automatic pin_ps(input logic d);
    set_pin(d, 1'b1);
    wait_cyc(6);
    wr_reg(8'h00, {28'h0, d, 2'b01, d});
    idle_ok <= 1'b1;
    wait_cyc(12);
    `CHK(port_en, 1'b1)
    `CHK(mode, 2'h0)
    `CHK(cts_n, 1'b0)
    `CHK(dtr_seen, d)
    set_pin(d, 1'b0);
    wait_cyc(6);
    `CHK(port_en, 1'b0)
    `CHK(cts_n, d)
    `CHK(rx_acc, 1'b0)
    @(posedge clk);
    unsol <= 1'b1;
    wait_cyc(4);
    `CHK(port_en, 1'b1)
    @(posedge clk);
    unsol <= 1'b0;
    if (!d) begin
      session <= 1'b1;
      wait_cyc(4);
      `CHK(port_en, 1'b1)
      @(posedge clk);
      session <= 1'b0;
    end
    wait_st(2'h1, 40);
    send_char;
    wait_cyc(10);
    `CHK(mode, 2'h1)
    set_pin(d, 1'b1);
    wait_st(2'h2, 8);
    `CHK(rx_acc, 1'b0)
    wait_cyc(WAKE - 4);
    `CHK(mode, 2'h2)
    wait_st(2'h0, 12);
    `CHK(port_en, 1'b1)
  endtask

  initial begin
    rv = $urandom(13);
    exp_ctrl = 7'h00;
    repeat (6) @(posedge clk);
    reset_n <= 1'b1;
    wait_cyc(1);
    `CHK(port_en, 1'b1)
    `CHK(cts_n, 1'b0)
    `CHK({mode, rx_acc}, 3'h1)
    rd_reg(8'h04);
    `CHK(rv, 32'h7d0)
    rd_reg(8'h10);
    `CHK(rv, 32'h0)
    for (int i = 0; i < 28; i++) begin
      w = (i < 4) ? corner[i] : 7'($urandom);
      wr_reg(8'h00, {25'h0, w});
      if (ctrl_ok(w)) begin
        exp_ctrl = w;
      end
      rd_reg(8'h00);
      `CHK(rv[6:0], exp_ctrl)
      rd_reg(8'h08);
      `CHK(rv[5], !ctrl_ok(w))
      wr_reg(8'h08, 32'h20);
    end
    for (int v = 0; v < 5; v++) begin
      wr_reg(8'h00, {25'h0, 3'(v), 4'h0});
      rd_reg(8'h0c);
      `CHK(rv[8:0], map_exp(3'(v)))
    end
    pin_ps(1'b0);
    pin_ps(1'b1);
    // Data wake in both timed settings
    for (int s = 1; s < 5; s += 3) begin
      wr_reg(8'h04, 32'h8);
      wr_reg(8'h00, {29'h0, 3'(s)});
      wait_st(2'h1, 80);
      `CHK(port_en, 1'b0)
      send_char;
      wait_st(2'h2, 10);
      `CHK(rx_acc, 1'b0)
      wait_st(2'h0, WAKE + 8);
      wait_cyc(2);
      `CHK(rx_acc, 1'b1)
      send_char;
      wait_cyc(9);
      `CHK(port_en, 1'b1)
      wait_st(2'h1, 30);
      `CHK(port_en, 1'b0)
      wr_reg(8'h00, {28'h0, 1'b1, 3'(s)});
      send_char;
      wait_cyc(10);
      `CHK(mode, 2'h1)
    end
    wr_reg(8'h00, 32'h1);
    deep_ok <= 1'b1;
    wait_st(2'h3, 10);
    `CHK(port_en, 1'b0)
    @(posedge clk);
    deep_ok <= 1'b0;
    wait_st(2'h2, 10);
    report_and_stop;
  end
endmodule
`default_nettype wire
